// File: tle_event_logic.sv
// Temperature limit event logic: limits, status flags, alert pin, locks and identity
`timescale 1ns/1ps

module tle_event_logic #(
    parameter logic [15:0] MAKER_CODE = 16'h1a2b, // Arbitrary value
    parameter logic [7:0] PART_ID = 8'h5c,         // Arbitrary value
    parameter logic [7:0] REVISION = 8'h01         // Arbitrary value
) (
    // Clock, reset and enable
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Register port from the serial protocol engine
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    // Resolution field from the resolution register
    input wire logic [1:0] resolution_field_i,
    // Converter link (clock and data in the converter clock domain)
    input wire logic conv_clk_i,
    input wire logic [12:0] conv_data_i,
    output logic power_down_o,
    // Open-drain alert pin
    input wire logic alert_in_i,
    output logic alert_o,
    output logic alert_oe_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [tle_pkg::SYNC_STAGES-1:0] clk_sync;
        logic clk_last;
        logic [12:0] data_s1;
        logic [12:0] data_s2;
        logic sample;
        logic [12:0] temp;
        // Limits keep only the compared bits 12..2; reads pad them back out
        logic [tle_pkg::CMP_W-1:0] upper;
        logic [tle_pkg::CMP_W-1:0] lower;
        logic [tle_pkg::CMP_W-1:0] critical;
        tle_pkg::tle_ctrl_t ctrl;
        logic cond_last;
        logic irq_latch;
        logic asserted;
        logic pin_drive;
        logic [15:0] rdata;
    } tle_state_t;

    tle_state_t state;
    tle_state_t next_state;
    tle_pkg::tle_reg_req_t req;
    // Status flags: 0 critical, 1 upper, 2 lower
    logic [2:0] flags;
    logic [tle_pkg::CMP_W-1:0] band;
    logic any_lock;
    logic cond;
    logic [15:0] wd;
    logic clear_req;

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic [tle_pkg::CMP_W-1:0] hyst_band(input logic [1:0] code);
        logic [tle_pkg::CMP_W-1:0] b;
        b = tle_pkg::HYST_NONE;
        unique case (code)
            2'h0: b = tle_pkg::HYST_NONE;
            2'h1: b = tle_pkg::HYST_1P5;
            2'h2: b = tle_pkg::HYST_3P0;
            2'h3: b = tle_pkg::HYST_6P0;
        endcase
        return b;
    endfunction

    // Applied at capture, so a later change of resolution leaves a stored sample alone
    function automatic logic [12:0] res_mask(input logic [1:0] code);
        logic [12:0] m;
        m = 13'h1fff;
        unique case (code)
            tle_pkg::RES_0P5: m = 13'h1ff8;
            tle_pkg::RES_0P25: m = 13'h1ffc;
            tle_pkg::RES_0P125: m = 13'h1ffe;
            default: m = 13'h1fff;
        endcase
        return m;
    endfunction

    function automatic logic [15:0] limit_word(input logic [tle_pkg::CMP_W-1:0] v);
        return {3'h0, v, 2'h0};
    endfunction

    // ------------------------------------------------------------
    // Limit comparators
    // ------------------------------------------------------------
    assign band = hyst_band(state.ctrl.hyst);

    logic [tle_pkg::CMP_W-1:0] limits [3];
    assign limits[0] = state.critical;
    assign limits[1] = state.upper;
    assign limits[2] = state.lower;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_cmp
            tle_limit_cmp #(
                .SENSE(gi == 2 ? tle_pkg::CMP_BELOW : tle_pkg::CMP_ABOVE)
            ) u_cmp (
                .clock_i(clock_i),
                .rst_n_i(rst_n_i),
                .ce_i(ce_i),
                .sample_i(state.sample),
                .temp_i(state.temp[tle_pkg::TEMP_MSB:tle_pkg::CMP_LSB]),
                .limit_i(limits[gi]),
                .band_i(band),
                .flag_o(flags[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    assign req.addr = reg_addr_i;
    assign req.wr = reg_wr_i;
    assign req.rd = reg_rd_i;
    assign req.wdata = reg_wdata_i;
    assign wd = req.wdata;
    // Either lock freezes hysteresis, enable and the setting of power down
    assign any_lock = state.ctrl.critical_limit_lock | state.ctrl.window_lock;
    assign cond = state.ctrl.alert_enable & (flags[0] |
        (~state.ctrl.critical_alert_only & (flags[1] | flags[2])));
    // Write-only: never stored, so it always reads back as zero
    assign clear_req = req.wr && (req.addr == tle_pkg::OFS_ALERT_CONTROL) &&
        wd[tle_pkg::CLEAR_BIT];

    always_comb begin
        next_state = state;

        // ------------------------------------------------------------
        // Converter link: edge found on the second synchroniser stage only
        // ------------------------------------------------------------
        next_state.clk_sync = {state.clk_sync[0], conv_clk_i};
        next_state.clk_last = state.clk_sync[1];
        next_state.data_s1 = conv_data_i;
        next_state.data_s2 = state.data_s1;
        next_state.sample = 1'b0;
        if (state.clk_sync[1] && !state.clk_last && !state.ctrl.power_down) begin
            next_state.temp = state.data_s2 & res_mask(resolution_field_i);
            next_state.sample = 1'b1;
        end

        // ------------------------------------------------------------
        // Register writes
        // ------------------------------------------------------------
        if (req.wr) begin
            unique case (req.addr)
                tle_pkg::OFS_ALERT_CONTROL: begin
                    if (!any_lock) begin
                        next_state.ctrl.hyst = wd[tle_pkg::HYST_HI:tle_pkg::HYST_LO];
                        next_state.ctrl.alert_enable = wd[tle_pkg::ALERT_EN_BIT];
                    end
                    if (!wd[tle_pkg::POWER_DOWN_BIT] || !any_lock) begin
                        next_state.ctrl.power_down = wd[tle_pkg::POWER_DOWN_BIT];
                    end
                    if (!state.ctrl.window_lock) begin
                        next_state.ctrl.critical_alert_only = wd[tle_pkg::CRIT_ONLY_BIT];
                    end
                    // Locks only ever set; reset is the sole way out
                    next_state.ctrl.critical_limit_lock = state.ctrl.critical_limit_lock |
                        wd[tle_pkg::CRIT_LOCK_BIT];
                    next_state.ctrl.window_lock = state.ctrl.window_lock |
                        wd[tle_pkg::WIN_LOCK_BIT];
                    next_state.ctrl.alert_polarity = wd[tle_pkg::POLARITY_BIT];
                    next_state.ctrl.alert_mode = wd[tle_pkg::MODE_BIT];
                end
                tle_pkg::OFS_UPPER_TRIP: begin
                    if (!state.ctrl.window_lock) begin
                        next_state.upper = wd[tle_pkg::TEMP_MSB:tle_pkg::CMP_LSB];
                    end
                end
                tle_pkg::OFS_LOWER_TRIP: begin
                    if (!state.ctrl.window_lock) begin
                        next_state.lower = wd[tle_pkg::TEMP_MSB:tle_pkg::CMP_LSB];
                    end
                end
                tle_pkg::OFS_CRITICAL_TRIP: begin
                    if (!state.ctrl.critical_limit_lock) begin
                        next_state.critical = wd[tle_pkg::TEMP_MSB:tle_pkg::CMP_LSB];
                    end
                end
                default: begin
                end
            endcase
        end

        // ------------------------------------------------------------
        // Alert: frozen while powered down, so no events arise there
        // ------------------------------------------------------------
        if (!state.ctrl.power_down) begin
            next_state.cond_last = cond;
            // Release first, so a new event in the same cycle still wins
            if (clear_req) begin
                next_state.irq_latch = 1'b0;
            end
            if (cond && !state.cond_last) begin
                next_state.irq_latch = 1'b1;
            end
            if (state.ctrl.alert_mode) begin
                next_state.asserted = next_state.irq_latch;
            end else begin
                // Latch tracks the live condition, so clear is ignored here and a
                // switch to interrupt mode does not replay an event long gone
                next_state.irq_latch = cond;
                next_state.asserted = cond;
            end
        end
        // Pin drive registered: a gate on two flops could glitch the open-drain pin
        next_state.pin_drive = next_state.asserted ^ next_state.ctrl.alert_polarity;

        // ------------------------------------------------------------
        // Register reads, answered one cycle after the strobe
        // ------------------------------------------------------------
        if (req.rd) begin
            unique case (req.addr)
                tle_pkg::OFS_ALERT_CONTROL: begin
                    next_state.rdata = {5'h00, state.ctrl.hyst, state.ctrl.power_down,
                        state.ctrl.critical_limit_lock, state.ctrl.window_lock, 1'b0,
                        state.asserted, state.ctrl.alert_enable,
                        state.ctrl.critical_alert_only, state.ctrl.alert_polarity,
                        state.ctrl.alert_mode};
                end
                tle_pkg::OFS_UPPER_TRIP: next_state.rdata = limit_word(state.upper);
                tle_pkg::OFS_LOWER_TRIP: next_state.rdata = limit_word(state.lower);
                tle_pkg::OFS_CRITICAL_TRIP: next_state.rdata = limit_word(state.critical);
                tle_pkg::OFS_MEASURED_TEMP: begin
                    next_state.rdata = {flags[0], flags[1], flags[2], state.temp};
                end
                tle_pkg::OFS_MAKER_CODE: next_state.rdata = MAKER_CODE;
                tle_pkg::OFS_PART_AND_REV: next_state.rdata = {PART_ID, REVISION};
                default: next_state.rdata = 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Synchronous reset; ce low holds every bit, synchronisers included
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state <= '0;
            state.ctrl.hyst <= tle_pkg::RST_HYST;
            state.upper <= tle_pkg::RST_LIMIT[tle_pkg::TEMP_MSB:tle_pkg::CMP_LSB];
            state.lower <= tle_pkg::RST_LIMIT[tle_pkg::TEMP_MSB:tle_pkg::CMP_LSB];
            state.critical <= tle_pkg::RST_LIMIT[tle_pkg::TEMP_MSB:tle_pkg::CMP_LSB];
            state.temp <= tle_pkg::RST_TEMP[12:0];
        end else if (ce_i) begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Open drain: the pin is pulled low only; a high level comes from the pull-up
    // The pin level is known from the drive state, so the readback input is not used
    tle_pkg::tle_pin_t pin;
    always_comb begin
        pin.out = 1'b0;
        pin.oe = state.pin_drive;
    end

    assign alert_o = pin.out;
    assign alert_oe_o = pin.oe;
    assign power_down_o = state.ctrl.power_down;
    assign reg_rdata_o = state.rdata;

endmodule

// File: tle_pkg.sv
// Package: register map, field layout and constants of the temperature limit event logic
package tle_pkg;

    // ------------------------------------------------------------
    // Register offsets (register pointer values)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_ALERT_CONTROL = 8'h01;
    localparam logic [7:0] OFS_UPPER_TRIP = 8'h02;
    localparam logic [7:0] OFS_LOWER_TRIP = 8'h03;
    localparam logic [7:0] OFS_CRITICAL_TRIP = 8'h04;
    localparam logic [7:0] OFS_MEASURED_TEMP = 8'h05;
    localparam logic [7:0] OFS_MAKER_CODE = 8'h06;
    localparam logic [7:0] OFS_PART_AND_REV = 8'h07;

    // ------------------------------------------------------------
    // Alert control field positions
    // ------------------------------------------------------------
    localparam int HYST_HI = 10;
    localparam int HYST_LO = 9;
    localparam int POWER_DOWN_BIT = 8;
    localparam int CRIT_LOCK_BIT = 7;
    localparam int WIN_LOCK_BIT = 6;
    localparam int CLEAR_BIT = 5;
    localparam int ALERT_FLAG_BIT = 4;
    localparam int ALERT_EN_BIT = 3;
    localparam int CRIT_ONLY_BIT = 2;
    localparam int POLARITY_BIT = 1;
    localparam int MODE_BIT = 0;

    // Measured temperature status bits
    localparam int CRIT_FLAG_BIT = 15;
    localparam int ABOVE_FLAG_BIT = 14;
    localparam int BELOW_FLAG_BIT = 13;

    // Temperature coding: sign at 12, comparisons use bits 12..2
    localparam int TEMP_MSB = 12;
    localparam int CMP_LSB = 2;
    localparam int CMP_W = TEMP_MSB - CMP_LSB + 1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_LIMIT = 16'h0000;
    localparam logic [15:0] RST_TEMP = 16'h0000;
    localparam logic [1:0] RST_HYST = 2'h0;

    // Hysteresis bands in units of the 0.25 degree comparator step
    localparam logic [CMP_W-1:0] HYST_NONE = 11'h000;
    localparam logic [CMP_W-1:0] HYST_1P5 = 11'h006;
    localparam logic [CMP_W-1:0] HYST_3P0 = 11'h00c;
    localparam logic [CMP_W-1:0] HYST_6P0 = 11'h018;

    // Resolution field codes
    localparam logic [1:0] RES_0P5 = 2'h0;
    localparam logic [1:0] RES_0P25 = 2'h1;
    localparam logic [1:0] RES_0P125 = 2'h2;

    // Synchroniser depth
    localparam int SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic {
        CMP_ABOVE,
        CMP_BELOW
    } tle_sense_t;

    typedef struct packed {
        logic [1:0] hyst;
        logic power_down;
        logic critical_limit_lock;
        logic window_lock;
        logic alert_enable;
        logic critical_alert_only;
        logic alert_polarity;
        logic alert_mode;
    } tle_ctrl_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [15:0] wdata;
    } tle_reg_req_t;

    typedef struct packed {
        logic out;
        logic oe;
    } tle_pin_t;

endpackage

// File: tle_limit_cmp.sv
// Single limit comparator with hysteresis and a held status flag
`timescale 1ns/1ps

module tle_limit_cmp #(
    parameter tle_pkg::tle_sense_t SENSE = tle_pkg::CMP_ABOVE
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Sample and limit
    input wire logic sample_i,
    input wire logic signed [tle_pkg::CMP_W-1:0] temp_i,
    input wire logic signed [tle_pkg::CMP_W-1:0] limit_i,
    input wire logic [tle_pkg::CMP_W-1:0] band_i,
    // Status
    output logic flag_o
);

    typedef struct packed {
        logic flag;
    } tle_cmp_state_t;

    tle_cmp_state_t state;
    tle_cmp_state_t next_state;
    logic signed [tle_pkg::CMP_W:0] t_ext;
    logic signed [tle_pkg::CMP_W:0] lim_ext;
    logic signed [tle_pkg::CMP_W:0] lim_band;

    // One extra bit so limit minus band never wraps
    assign t_ext = {temp_i[tle_pkg::CMP_W-1], temp_i};
    assign lim_ext = {limit_i[tle_pkg::CMP_W-1], limit_i};
    assign lim_band = lim_ext - $signed({1'b0, band_i});

    always_comb begin
        next_state = state;
        if (sample_i) begin
            if (SENSE == tle_pkg::CMP_ABOVE) begin
                if (t_ext > lim_ext) begin
                    next_state.flag = 1'b1;
                end else if (t_ext <= lim_band) begin
                    next_state.flag = 1'b0;
                end
            end else begin
                if (t_ext < lim_band) begin
                    next_state.flag = 1'b1;
                end else if (t_ext >= lim_ext) begin
                    next_state.flag = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state <= '0;
        end else if (ce_i) begin
            state <= next_state;
        end
    end

    assign flag_o = state.flag;

endmodule

// File: tle_event_logic_monitor.sv
// Concurrent checks on the ports of the temperature limit event logic
`timescale 1ns/1ps

module tle_event_logic_monitor #(
    parameter logic [15:0] MAKER_CODE = 16'h1a2b,
    parameter logic [7:0] PART_ID = 8'h5c,
    parameter logic [7:0] REVISION = 8'h01
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic [15:0] reg_rdata_o,
    // Resolution and converter link
    input wire logic [1:0] resolution_field_i,
    input wire logic conv_clk_i,
    input wire logic [12:0] conv_data_i,
    input wire logic power_down_o,
    // Alert pin
    input wire logic alert_in_i,
    input wire logic alert_o,
    input wire logic alert_oe_o
);
    localparam logic [7:0] CFG = tle_pkg::OFS_ALERT_CONTROL;

    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    clear_reads_zero_a: assert property (reg_rd_i && ce_i && reg_addr_i == CFG |=>
        reg_rdata_o[5] == 1'b0 && reg_rdata_o[15:11] == 5'h00)
        else $error("clear bit or reserved bits read nonzero");
    // Status bit and pin must agree, judged through the polarity read alongside
    flag_pin_a: assert property (reg_rd_i && ce_i && !reg_wr_i && reg_addr_i == CFG |=>
        reg_rdata_o[4] == ($past(alert_oe_o) ^ reg_rdata_o[1]))
        else $error("alert status bit disagrees with pin");
    maker_read_a: assert property (reg_rd_i && ce_i && reg_addr_i == 8'h06 |=>
        reg_rdata_o == MAKER_CODE)
        else $error("maker register wrong");
    part_read_a: assert property (reg_rd_i && ce_i && reg_addr_i == 8'h07 |=>
        reg_rdata_o == {PART_ID, REVISION})
        else $error("part and revision register wrong");
    limit_bits_a: assert property (reg_rd_i && ce_i && reg_addr_i inside {8'h02, 8'h03, 8'h04}
        |=> reg_rdata_o[15:13] == 3'h0 && reg_rdata_o[1:0] == 2'h0)
        else $error("limit register unused bits nonzero");

    // ------------------------------------------------------------
    // Power down and pin
    // ------------------------------------------------------------
    pd_set_a: assert property ($rose(power_down_o) |->
        $past(reg_wr_i && ce_i && reg_addr_i == CFG && reg_wdata_i[8]))
        else $error("power down set without a write");
    pd_clear_a: assert property (reg_wr_i && ce_i && reg_addr_i == CFG && !reg_wdata_i[8]
        |=> !power_down_o)
        else $error("power down not cleared");
    pd_hold_a: assert property (power_down_o && !(reg_wr_i && reg_addr_i == CFG)
        |=> power_down_o)
        else $error("power down dropped by itself");
    open_drain_a: assert property (alert_o == 1'b0)
        else $error("alert pin value not low");
endmodule

// File: tle_conv_model.sv
// Converter side model: one sample per link clock period
`timescale 1ns/1ps

module tle_conv_model (
    // Link to the device
    output logic conv_clk_o,
    output logic [12:0] conv_data_o
);
    initial begin
        conv_clk_o = 1'b0;
        conv_data_o = 13'h0aaa;
    end

    // Link clock stands low between samples; data settles a half period before the rise
    task automatic send(input logic [12:0] d);
        conv_data_o = d;
        #62.5;
        conv_clk_o = 1'b1;
        #62.5;
        conv_clk_o = 1'b0;
        // Hold is over: show the inverse so a late capture cannot pass by luck
        conv_data_o = ~d;
    endtask
endmodule

// File: tle_event_logic_tb.sv
// Self-checking testbench of the temperature limit event logic
`timescale 1ns/1ps

module tle_event_logic_tb;
    localparam logic [15:0] MK = 16'h3c5a; // Arbitrary value
    localparam logic [7:0] PID = 8'h7e; // Arbitrary value
    localparam logic [7:0] REV = 8'h02; // Arbitrary value
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ce = 1'b1;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] wdata = 16'h0000;
    logic [1:0] res = 2'h0;
    logic [15:0] rdata;
    logic conv_clk;
    logic [12:0] conv_data;
    logic pd;
    logic a_out;
    logic a_oe;
    wire pin = a_oe ? 1'b0 : 1'b1;
    int err_total = 0;
    int samples_checked = 0;
    // Reference state
    logic [15:0] cfg = 16'h0000;
    logic [15:0] lim [2:4] = '{16'h0000, 16'h0000, 16'h0000};
    logic [15:0] treg = 16'h0000;
    logic asrt = 1'b0;
    logic cond_q = 1'b0;

    always #2 clock_i = ~clock_i;

    tle_event_logic #(.MAKER_CODE(MK), .PART_ID(PID), .REVISION(REV)) u_tle_event_logic (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .resolution_field_i(res), .conv_clk_i(conv_clk),
        .conv_data_i(conv_data), .power_down_o(pd), .alert_in_i(pin),
        .alert_o(a_out), .alert_oe_o(a_oe));
    tle_conv_model u_tle_conv_model (.conv_clk_o(conv_clk), .conv_data_o(conv_data));

    // ------------------------------------------------------------
    // Reference helpers
    // ------------------------------------------------------------
    function automatic int band(input logic [1:0] h);
        return (h == 2'h0) ? 0 : (h == 2'h1) ? 6 : (h == 2'h2) ? 12 : 24;
    endfunction
    function automatic int tv(input logic [15:0] v);
        return int'($signed(v[12:2]));
    endfunction
    function automatic logic [12:0] pick();
        int t;
        t = tv(lim[2 + $urandom_range(2)]) + int'($urandom_range(60)) - 30;
        return {11'(t), 2'($urandom)};
    endfunction
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic eval();
        logic c;
        c = cfg[3] & (treg[15] | (~cfg[2] & (treg[14] | treg[13])));
        if (!cfg[8]) begin
            if (!cfg[0]) asrt = c;
            else if (c & ~cond_q) asrt = 1'b1;
            cond_q = c;
        end
    endtask
    task automatic wrap_up();
        if (err_total == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Register and sample transfers
    // ------------------------------------------------------------
    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        logic lk;
        @(posedge clock_i);
        #1;
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clock_i);
        #1;
        wr = 1'b0;
        lk = cfg[7] | cfg[6];
        if (a == 8'h01) begin
            if (cfg[0] && d[5]) asrt = 1'b0;
            cfg[1:0] = d[1:0];
            if (!cfg[6]) cfg[2] = d[2];
            if (!lk) cfg[3] = d[3];
            if (!d[8] || !lk) cfg[8] = d[8];
            if (!lk) cfg[10:9] = d[10:9];
            cfg[7:6] = cfg[7:6] | d[7:6];
        end
        if ((a == 8'h04 && !cfg[7]) || ((a == 8'h02 || a == 8'h03) && !cfg[6])) begin
            lim[a] = d & 16'h1ffc;
        end
        eval();
    endtask
    task automatic rreg(input logic [7:0] a);
        logic [15:0] e;
        @(posedge clock_i);
        #1;
        addr = a;
        rd = 1'b1;
        @(posedge clock_i);
        #1;
        rd = 1'b0;
        case (a)
            8'h01: e = cfg | {11'h000, asrt, 4'h0};
            8'h02, 8'h03, 8'h04: e = lim[a];
            8'h05: e = treg;
            8'h06: e = MK;
            8'h07: e = {PID, REV};
            default: e = 16'h0000;
        endcase
        chk($sformatf("register %h", a), e, rdata);
    endtask
    task automatic smp(input logic [12:0] d);
        logic [12:0] m;
        int t;
        int b;
        @(posedge clock_i);
        #1;
        res = 2'($urandom_range(3));
        u_tle_conv_model.send(d);
        repeat (10) @(posedge clock_i);
        if (!cfg[8]) begin
            m = d & (13'h1fff << (2'd3 - res));
            t = tv({3'h0, m});
            b = band(cfg[10:9]);
            if (t > tv(lim[2])) treg[14] = 1'b1;
            else if (t <= tv(lim[2]) - b) treg[14] = 1'b0;
            if (t > tv(lim[4])) treg[15] = 1'b1;
            else if (t <= tv(lim[4]) - b) treg[15] = 1'b0;
            if (t < tv(lim[3]) - b) treg[13] = 1'b1;
            else if (t >= tv(lim[3])) treg[13] = 1'b0;
            treg[12:0] = m;
            eval();
        end
        chk("alert_oe", {15'h0000, asrt ^ cfg[1]}, {15'h0000, a_oe});
        rreg(8'h05);
        rreg(8'h01);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hfaa4));
        repeat (12) @(posedge clock_i);
        #1;
        rst_n_i = 1'b1;
        for (int a = 1; a < 10; a++) rreg(8'(a));
        wreg(8'h02, 16'h01e0);
        wreg(8'h03, 16'h00a0);
        wreg(8'h04, 16'h0320);
        for (int h = 0; h < 4; h++) begin
            wreg(8'h01, {5'h00, 2'(h), 9'h008});
            smp(13'((122 - band(2'(h))) * 4));
            smp(13'((122 - band(2'(h))) * 4));
            smp(13'((120 - band(2'(h))) * 4));
            smp(13'((38 - band(2'(h))) * 4));
            smp(13'(38 * 4));
            smp(13'(40 * 4));
        end
        for (int i = 0; i < 48; i++) begin
            if (i % 6 == 0) wreg(8'h01, {5'h00, 11'($urandom) & 11'h60e} | 16'(i >= 24));
            if (i % 6 == 0 && i >= 24) wreg(8'h01, cfg | 16'h0020);
            if (i >= 24 && $urandom_range(1) == 1) wreg(8'h01, cfg | 16'h0020);
            smp(pick());
        end
        wreg(8'h01, cfg | 16'h0100);
        smp(13'h07fc);
        wreg(8'h01, cfg | 16'h0080);
        wreg(8'h01, cfg & 16'hfeff);
        wreg(8'h01, cfg ^ 16'h070c);
        wreg(8'h04, 16'h0100);
        wreg(8'h02, 16'h0200);
        for (int a = 1; a < 6; a++) rreg(8'(a));
        wreg(8'h01, cfg | 16'h0040);
        wreg(8'h01, cfg ^ 16'h0004);
        wreg(8'h02, 16'h01e0);
        wreg(8'h03, 16'h0010);
        wreg(8'h01, 16'h0000);
        for (int a = 1; a < 6; a++) rreg(8'(a));
        repeat (8) smp(pick());
        // Mid-run reset: locks may only fall here
        rst_n_i = 1'b0;
        repeat (2) @(posedge clock_i);
        #1;
        rst_n_i = 1'b1;
        cfg = 16'h0000;
        lim = '{16'h0000, 16'h0000, 16'h0000};
        treg = 16'h0000;
        asrt = 1'b0;
        cond_q = 1'b0;
        for (int a = 1; a < 6; a++) rreg(8'(a));
        // Enable low: the write must not land
        ce = 1'b0;
        wreg(8'h02, 16'h0100);
        lim[2] = 16'h0000;
        ce = 1'b1;
        rreg(8'h02);
        wreg(8'h02, 16'h0100);
        rreg(8'h02);
        wrap_up();
    end

    initial begin
        repeat (100000) @(posedge clock_i);
        err_total++;
        wrap_up();
    end
endmodule

bind tle_event_logic tle_event_logic_monitor #(
    .MAKER_CODE(MAKER_CODE), .PART_ID(PART_ID), .REVISION(REVISION)
) u_tle_event_logic_monitor (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .resolution_field_i(resolution_field_i),
    .conv_clk_i(conv_clk_i), .conv_data_i(conv_data_i), .power_down_o(power_down_o),
    .alert_in_i(alert_in_i), .alert_o(alert_o), .alert_oe_o(alert_oe_o));
